// >>> rtl/sfcd_regs.svh
// Constants of the serial flash command decoder
// Assumes inclusion by bare name from rtl files
`ifndef SFCD_REGS_SVH
`define SFCD_REGS_SVH
`define SFCD_OP_WREN    8'h06
`define SFCD_OP_WRREG   8'h71
`define SFCD_OP_CLRFAIL 8'h30
`define SFCD_OP_EN4     8'hb7
`define SFCD_OP_EX4     8'hb8
`define SFCD_OP_RDLP    8'h41
`define SFCD_OP_PRLP    8'h43
`define SFCD_OP_WRLP    8'h4a
`define SFCD_OP_BOOT    8'h15
`define SFCD_OP_ECC_M   8'h19
`define SFCD_OP_ECC_4   8'h18
`define SFCD_OP_CLEAR_ECC_STATE_CMD   8'h1b
`define SFCD_OP_CHK     8'h5b
`define SFCD_ALEN_3     4'h3
`define SFCD_ALEN_4     4'h4
`define SFCD_ALEN_CHK   4'h8
`define SFCD_CNT_MAX    4'hf
`define SFCD_OFS_CTRL   8'h00
`define SFCD_OFS_STAT1  8'h04
`define SFCD_OFS_CFG2   8'h08
`define SFCD_OFS_LPV    8'h0c
`define SFCD_OFS_LPNV   8'h10
`define SFCD_OFS_BOOT   8'h14
`define SFCD_OFS_ECC    8'h18
`define SFCD_OFS_TRAP   8'h1c
`define SFCD_OFS_ECNT   8'h20
`define SFCD_OFS_RSTA   8'h24
`define SFCD_OFS_REND   8'h28
`define SFCD_OFS_IRQST  8'h2c
`define SFCD_OFS_IRQEN  8'h30
`define SFCD_OFS_IRQCLR 8'h34
`define SFCD_OFS_ANY    8'h40
`define SFCD_ANY_MASK   8'hc0
`define SFCD_BIT_WEL    1
`define SFCD_BIT_EFAIL  5
`define SFCD_BIT_PFAIL  6
`define SFCD_BIT_ALEN   7
`define SFCD_BIT_ECC1   3
`define SFCD_BIT_ECC2   4
`define SFCD_BIT_NOCLR  0
`define SFCD_EV_REGWR   0
`define SFCD_EV_FCLR    1
`define SFCD_EV_RESUME  2
`define SFCD_EV_CHK     3
`define SFCD_EV_DENY    4
`define SFCD_EV_BOOT    5
`define SFCD_NEV        6
`define SFCD_RESP_OK    2'b00
`define SFCD_RESP_ERR   2'b10
`endif

// >>> rtl/sfcd_pkg.sv
// Types of the serial flash command decoder
// Assumes sfcd_regs.svh for numeric constants
package sfcd_pkg;
    typedef enum logic [1:0] {
        SFCD_PH_OPC  = 2'b00,
        SFCD_PH_ADDR = 2'b01,
        SFCD_PH_DATA = 2'b10,
        SFCD_PH_DONE = 2'b11
    } sfcd_phase_t;
endpackage

// >>> rtl/sfcd_spi_port.sv
// Serial pin front end: synchronisers, byte receive, byte send
// Assumes mode 0 link much slower than aclk
`timescale 1ns/1ps
`default_nettype none
module sfcd_spi_port (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic            rx_vld,
    output logic [7:0]      rx_byte,
    output logic            frm_start,
    output logic            frm_end,
    output logic            cs_act,
    output logic            miso
);
    logic [1:0] cs_s_q, sck_s_q, mosi_s_q;
    logic       cs_p_q, sck_p_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q, tx_q;
    logic       rise, fall;

    // Two-stage synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_s_q   <= 2'h3;
            sck_s_q  <= 2'h0;
            mosi_s_q <= 2'h0;
            cs_p_q   <= 1'b1;
            sck_p_q  <= 1'b0;
        end else begin
            cs_s_q   <= {cs_s_q[0], cs_n};
            sck_s_q  <= {sck_s_q[0], sck};
            mosi_s_q <= {mosi_s_q[0], mosi};
            cs_p_q   <= cs_s_q[1];
            sck_p_q  <= sck_s_q[1];
        end
    end

    assign cs_act    = !cs_s_q[1];
    assign rise      = cs_act && sck_s_q[1] && !sck_p_q;
    assign fall      = cs_act && !sck_s_q[1] && sck_p_q;
    assign frm_start = !cs_s_q[1] && cs_p_q;
    assign frm_end   = cs_s_q[1] && !cs_p_q;

    // Receive on rising edges
    always_ff @(posedge aclk) begin
        if (!aresetn || !cs_act) begin
            bit_q   <= 3'h0;
            sh_q    <= 8'h00;
            rx_vld  <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_vld <= 1'b0;
            if (rise) begin
                bit_q <= bit_q + 3'h1;
                sh_q  <= {sh_q[6:0], mosi_s_q[1]};
                if (bit_q == 3'h7) begin
                    rx_vld  <= 1'b1;
                    rx_byte <= {sh_q[6:0], mosi_s_q[1]};
                end
            end
        end
    end

    // Send on falling edges, reload at byte boundary
    always_ff @(posedge aclk) begin
        if (!aresetn || !cs_act) begin
            tx_q <= 8'h00;
        end else if (fall) begin
            tx_q <= (bit_q == 3'h0) ? tx_byte : {tx_q[6:0], 1'b0};
        end
    end

    assign miso = tx_q[7];
endmodule
`default_nettype wire

// >>> rtl/sfcd_decoder.sv
// Serial flash register command decoder with AXI4-Lite register view
// Assumes host drives cs_n, sck, mosi in mode 0, single lane
// Function
// - Opcode 71 after write enable takes an address and one byte and stores it in that register.
// - Opcode 71 uses three address bytes, or four sent high byte first in wide mode.
// - Opcode 30 clears the erase and program failure flags of status register 1.
// - With the disable bit of the control register set, opcode 30 becomes a resume request.
// - Opcode B7 sets the address length bit, selecting four-byte addressing.
// - Opcode B8 clears the address length bit, returning to three-byte addressing.
// - Opcode 41 shifts out the volatile learning pattern.
// - Opcode 43 after write enable programs one byte into the nonvolatile learning pattern.
// - Opcode 4A after write enable writes one byte into the volatile learning pattern.
// - Opcode 15 after write enable streams bytes in order into the boot pattern.
// - Opcodes 19 and 18 return ECC status, 19 with mode address length, 18 with four bytes.
// - Opcode 1B clears both ECC flags, the address trap and the error counter.
// - Opcode 5B takes a four-byte start and end address and starts a range check.
// - Opcode 06 sets the write enable latch, which gates opcodes 71, 43, 4A and 15.
`timescale 1ns/1ps
`default_nettype none
`include "sfcd_regs.svh"
module sfcd_decoder (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    output logic             resume_req,
    output logic             chk_start,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic                 rx_vld, frm_start, frm_end, cs_act, tx_on;
    logic [7:0]           rx_byte, tx_byte, opc_q;
    logic [3:0]           cnt_q, alen;
    logic [63:0]          addr_q;
    sfcd_pkg::sfcd_phase_t ph_q;
    logic                 wel_q, efail_q, pfail_q, wide_q, noclr_q, wrote_q;
    logic                 ecc1_q, ecc2_q;
    logic [7:0]           lpv_q, lpnv_q, trap_q, ecnt_q;
    logic [31:0]          boot_q, rsta_q, rend_q;
    logic [7:0]           any_q [16];
    logic [`SFCD_NEV-1:0] ev, ist_q, ien_q;
    logic                 wr_go, op_go, dat_go, need_wel, denied;
    logic [7:0]           w_off;
    logic [31:0]          rd_d;
    logic [1:0]           rd_resp;

    sfcd_spi_port u_port (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .cs_n      (cs_n),
        .sck       (sck),
        .mosi      (mosi),
        .tx_byte   (tx_byte),
        .rx_vld    (rx_vld),
        .rx_byte   (rx_byte),
        .frm_start (frm_start),
        .frm_end   (frm_end),
        .cs_act    (cs_act),
        .miso      (miso)
    );

    // Address length per opcode
    always_comb begin
        case (opc_q)
            `SFCD_OP_WRREG: alen = wide_q ? `SFCD_ALEN_4 : `SFCD_ALEN_3;
            `SFCD_OP_ECC_M: alen = wide_q ? `SFCD_ALEN_4 : `SFCD_ALEN_3;
            `SFCD_OP_ECC_4: alen = `SFCD_ALEN_4;
            `SFCD_OP_CHK:   alen = `SFCD_ALEN_CHK;
            default:        alen = 4'h0;
        endcase
    end

    assign op_go  = rx_vld && (ph_q == sfcd_pkg::SFCD_PH_OPC);
    assign dat_go = rx_vld && (ph_q == sfcd_pkg::SFCD_PH_DATA);
    assign need_wel = (rx_byte == `SFCD_OP_WRREG) || (rx_byte == `SFCD_OP_PRLP)
                   || (rx_byte == `SFCD_OP_WRLP) || (rx_byte == `SFCD_OP_BOOT);
    assign denied = op_go && need_wel && !wel_q;

    // Frame sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn || frm_start) begin
            ph_q   <= sfcd_pkg::SFCD_PH_OPC;
            cnt_q  <= 4'h0;
            opc_q  <= 8'h00;
            addr_q <= 64'h0;
        end else if (rx_vld) begin
            if (cnt_q != `SFCD_CNT_MAX) begin
                cnt_q <= cnt_q + 4'h1;
            end
            case (ph_q)
                sfcd_pkg::SFCD_PH_OPC: begin
                    opc_q <= rx_byte;
                    if (denied) begin
                        ph_q <= sfcd_pkg::SFCD_PH_DONE;
                    end else if (rx_byte == `SFCD_OP_WRREG || rx_byte == `SFCD_OP_ECC_M
                                 || rx_byte == `SFCD_OP_ECC_4
                                 || rx_byte == `SFCD_OP_CHK) begin
                        ph_q <= sfcd_pkg::SFCD_PH_ADDR;
                    end else if (need_wel) begin
                        ph_q <= sfcd_pkg::SFCD_PH_DATA;
                    end else begin
                        ph_q <= sfcd_pkg::SFCD_PH_DONE;
                    end
                end
                sfcd_pkg::SFCD_PH_ADDR: begin
                    addr_q <= {addr_q[55:0], rx_byte};
                    if (cnt_q == alen) begin
                        ph_q <= (opc_q == `SFCD_OP_WRREG) ? sfcd_pkg::SFCD_PH_DATA
                                                          : sfcd_pkg::SFCD_PH_DONE;
                    end
                end
                sfcd_pkg::SFCD_PH_DATA: begin
                    if (opc_q != `SFCD_OP_BOOT) begin
                        ph_q <= sfcd_pkg::SFCD_PH_DONE;
                    end
                end
                default: ph_q <= sfcd_pkg::SFCD_PH_DONE;
            endcase
        end
    end

    // Write enable latch, dropped at end of a frame that wrote
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wel_q   <= 1'b0;
            wrote_q <= 1'b0;
        end else begin
            if (op_go && rx_byte == `SFCD_OP_WREN) begin
                wel_q <= 1'b1;
            end else if (frm_end && wrote_q) begin
                wel_q <= 1'b0;
            end
            if (frm_start) begin
                wrote_q <= 1'b0;
            end else if (dat_go) begin
                wrote_q <= 1'b1;
            end
        end
    end

    // Mode and failure flags; software injection wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wide_q  <= 1'b0;
            efail_q <= 1'b0;
            pfail_q <= 1'b0;
        end else begin
            if (op_go && rx_byte == `SFCD_OP_EN4) begin
                wide_q <= 1'b1;
            end else if (op_go && rx_byte == `SFCD_OP_EX4) begin
                wide_q <= 1'b0;
            end
            if (wr_go && w_off == `SFCD_OFS_STAT1 && s_axi_wdata[`SFCD_BIT_EFAIL]) begin
                efail_q <= 1'b1;
            end else if (ev[`SFCD_EV_FCLR]) begin
                efail_q <= 1'b0;
            end
            if (wr_go && w_off == `SFCD_OFS_STAT1 && s_axi_wdata[`SFCD_BIT_PFAIL]) begin
                pfail_q <= 1'b1;
            end else if (ev[`SFCD_EV_FCLR]) begin
                pfail_q <= 1'b0;
            end
        end
    end

    // Data bytes into pattern registers and register file
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lpv_q  <= 8'h00;
            lpnv_q <= 8'h00;
            boot_q <= 32'h0;
            for (int i = 0; i < 16; i++) begin
                any_q[i] <= 8'h00;
            end
        end else if (dat_go) begin
            case (opc_q)
                `SFCD_OP_WRREG: any_q[addr_q[3:0]] <= rx_byte;
                `SFCD_OP_PRLP:  lpnv_q <= rx_byte;
                `SFCD_OP_WRLP:  lpv_q <= rx_byte;
                `SFCD_OP_BOOT:  boot_q <= {boot_q[23:0], rx_byte};
                default:        lpv_q <= lpv_q;
            endcase
        end else if (wr_go && w_off == `SFCD_OFS_LPV && s_axi_wstrb[0]) begin
            lpv_q <= s_axi_wdata[7:0];
        end
    end

    // ECC state; software injection wins over the clear command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ecc1_q <= 1'b0;
            ecc2_q <= 1'b0;
            trap_q <= 8'h00;
            ecnt_q <= 8'h00;
        end else if (wr_go && w_off == `SFCD_OFS_ECC) begin
            ecc1_q <= s_axi_wdata[`SFCD_BIT_ECC1];
            ecc2_q <= s_axi_wdata[`SFCD_BIT_ECC2];
        end else if (wr_go && w_off == `SFCD_OFS_TRAP) begin
            trap_q <= s_axi_wdata[7:0];
        end else if (wr_go && w_off == `SFCD_OFS_ECNT) begin
            ecnt_q <= s_axi_wdata[7:0];
        end else if (op_go && rx_byte == `SFCD_OP_CLEAR_ECC_STATE_CMD) begin
            ecc1_q <= 1'b0;
            ecc2_q <= 1'b0;
            trap_q <= 8'h00;
            ecnt_q <= 8'h00;
        end
    end

    // Range check capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsta_q    <= 32'h0;
            rend_q    <= 32'h0;
            chk_start <= 1'b0;
        end else begin
            chk_start <= ev[`SFCD_EV_CHK];
            if (ev[`SFCD_EV_CHK]) begin
                rsta_q <= addr_q[55:24];
                rend_q <= {addr_q[23:0], rx_byte};
            end
        end
    end

    // Resume request pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resume_req <= 1'b0;
        end else begin
            resume_req <= ev[`SFCD_EV_RESUME];
        end
    end

    // Events
    assign ev[`SFCD_EV_REGWR]  = dat_go && opc_q == `SFCD_OP_WRREG;
    assign ev[`SFCD_EV_FCLR]   = op_go && rx_byte == `SFCD_OP_CLRFAIL && !noclr_q;
    assign ev[`SFCD_EV_RESUME] = op_go && rx_byte == `SFCD_OP_CLRFAIL && noclr_q;
    assign ev[`SFCD_EV_CHK]    = rx_vld && ph_q == sfcd_pkg::SFCD_PH_ADDR
                              && opc_q == `SFCD_OP_CHK && cnt_q == `SFCD_ALEN_CHK;
    assign ev[`SFCD_EV_DENY]   = denied;
    assign ev[`SFCD_EV_BOOT]   = dat_go && opc_q == `SFCD_OP_BOOT;

    // Read data source
    assign tx_on = cs_act && ((opc_q == `SFCD_OP_RDLP && cnt_q != 4'h0)
                 || ((opc_q == `SFCD_OP_ECC_M || opc_q == `SFCD_OP_ECC_4)
                     && ph_q == sfcd_pkg::SFCD_PH_DONE));
    always_comb begin
        if (opc_q == `SFCD_OP_RDLP) begin
            tx_byte = lpv_q;
        end else if (tx_on) begin
            tx_byte = 8'h00;
            tx_byte[`SFCD_BIT_ECC1] = ecc1_q;
            tx_byte[`SFCD_BIT_ECC2] = ecc2_q;
        end else begin
            tx_byte = 8'h00;
        end
    end
    assign miso_oe = tx_on;

    // Interrupt status, enable and clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_q   <= '0;
            ien_q   <= '0;
            noclr_q <= 1'b0;
        end else begin
            if (wr_go && w_off == `SFCD_OFS_IRQCLR) begin
                ist_q <= (ist_q & ~s_axi_wdata[`SFCD_NEV-1:0]) | ev;
            end else begin
                ist_q <= ist_q | ev;
            end
            if (wr_go && w_off == `SFCD_OFS_IRQEN) begin
                ien_q <= s_axi_wdata[`SFCD_NEV-1:0];
            end
            if (wr_go && w_off == `SFCD_OFS_CTRL) begin
                noclr_q <= s_axi_wdata[`SFCD_BIT_NOCLR];
            end
        end
    end
    assign irq = |(ist_q & ien_q);

    // AXI4-Lite write channel
    assign w_off         = {s_axi_awaddr[7:2], 2'b00};
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SFCD_RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (w_off == `SFCD_OFS_CTRL || w_off == `SFCD_OFS_STAT1
                || w_off == `SFCD_OFS_LPV || w_off == `SFCD_OFS_ECC
                || w_off == `SFCD_OFS_TRAP || w_off == `SFCD_OFS_ECNT
                || w_off == `SFCD_OFS_IRQEN || w_off == `SFCD_OFS_IRQCLR) begin
                s_axi_bresp <= `SFCD_RESP_OK;
            end else begin
                s_axi_bresp <= `SFCD_RESP_ERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read decode
    always_comb begin
        rd_d    = 32'h0;
        rd_resp = `SFCD_RESP_OK;
        if (s_axi_araddr[7:2] == `SFCD_OFS_CTRL >> 2) begin
            rd_d[`SFCD_BIT_NOCLR] = noclr_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_STAT1 >> 2) begin
            rd_d[`SFCD_BIT_WEL]   = wel_q;
            rd_d[`SFCD_BIT_EFAIL] = efail_q;
            rd_d[`SFCD_BIT_PFAIL] = pfail_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_CFG2 >> 2) begin
            rd_d[`SFCD_BIT_ALEN] = wide_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_LPV >> 2) begin
            rd_d[7:0] = lpv_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_LPNV >> 2) begin
            rd_d[7:0] = lpnv_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_BOOT >> 2) begin
            rd_d = boot_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_ECC >> 2) begin
            rd_d[`SFCD_BIT_ECC1] = ecc1_q;
            rd_d[`SFCD_BIT_ECC2] = ecc2_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_TRAP >> 2) begin
            rd_d[7:0] = trap_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_ECNT >> 2) begin
            rd_d[7:0] = ecnt_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_RSTA >> 2) begin
            rd_d = rsta_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_REND >> 2) begin
            rd_d = rend_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_IRQST >> 2) begin
            rd_d[`SFCD_NEV-1:0] = ist_q;
        end else if (s_axi_araddr[7:2] == `SFCD_OFS_IRQEN >> 2) begin
            rd_d[`SFCD_NEV-1:0] = ien_q;
        end else if ((s_axi_araddr & `SFCD_ANY_MASK) == `SFCD_OFS_ANY) begin
            rd_d[7:0] = any_q[s_axi_araddr[5:2]];
        end else begin
            rd_resp = `SFCD_RESP_ERR;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `SFCD_RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rd_resp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/sfcd_host_model.sv
// Host side of the serial link: mode 0 frames, one lane, 400 ns sck
// Assumes a 50 ns aclk; sck stands low between frames
`timescale 1ns/1ps
`default_nettype none
module sfcd_host_model (
    input  wire logic aclk,
    output logic      cs_n = 1'b1,
    output logic      sck = 1'b0,
    output logic      mosi = 1'b0,
    input  wire logic miso
);
    task automatic hw(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Sends the bytes in one frame, returns the last byte seen on miso
    task automatic frame(input logic [7:0] q[$], output logic [7:0] rx);
        logic [7:0] s;
        s = 8'h00;
        @(posedge aclk);
        cs_n <= 1'b0;
        hw(4);
        foreach (q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                mosi <= q[i][b];
                hw(4);
                sck <= 1'b1;
                s = {s[6:0], miso};
                hw(4);
                sck <= 1'b0;
            end
        end
        hw(4);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        hw(8);
        rx = s;
    endtask
endmodule
`default_nettype wire

// >>> bench/sfcd_decoder_properties.sv
// Bus and link timing checks of the command decoder
// Assumes binding to sfcd_decoder, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sfcd_decoder_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cs_n,
    input wire logic        miso_oe,
    input wire logic        resume_req,
    input wire logic        chk_start,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        |=> s_axi_bvalid) else $error("write response missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
        |=> s_axi_rvalid) else $error("read response missing");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_refused: assert property (s_axi_rvalid
        |-> !s_axi_arready) else $error("read taken while busy");
    a_oe_idle: assert property (cs_n [*6] |-> !miso_oe)
        else $error("miso driven out of frame");
    a_chk_pulse: assert property (chk_start |-> !cs_n ##1 !chk_start)
        else $error("check start out of place");
    a_resume_pulse: assert property (resume_req |-> !cs_n ##1 !resume_req)
        else $error("resume out of place");
endmodule
bind sfcd_decoder sfcd_decoder_properties chk_u (.aclk, .aresetn, .cs_n, .miso_oe,
    .resume_req, .chk_start, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> bench/sfcd_decoder_tb.sv
// Self-checking bench of the serial flash command decoder
// Assumes host model on the link and AXI4-Lite tasks here
`timescale 1ns/1ps
`default_nettype none
`include "sfcd_regs.svh"
module sfcd_decoder_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        cs_n, sck, mosi, miso, miso_oe, resume_req, chk_start, irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx, b1, b2;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  q[$];
    int          fail_count = 0, n_tests = 0;
    sfcd_decoder dut_u (.*);
    sfcd_host_model host_u (.aclk, .cs_n, .sck, .mosi, .miso);
    always #25 aclk = ~aclk;
    function automatic logic [31:0] boot_exp(input logic [7:0] s[$]);
        boot_exp = 32'h0;
        foreach (s[i]) boot_exp = {boot_exp[23:0], s[i]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        r = s_axi_rresp;
        chk(nm, s_axi_rdata, e);
    endtask
    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end
    initial begin
        v = $urandom(18);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rc(`SFCD_OFS_STAT1, 32'h0, "stat1 reset");
        rc(8'h38, 32'h0, "unmapped data");
        chk("unmapped resp", r, `SFCD_RESP_ERR);
        wr(`SFCD_OFS_IRQEN, 32'h10);
        b1 = 8'($urandom) | 8'h01;
        host_u.frame({`SFCD_OP_WRLP, b1}, rx);
        rc(`SFCD_OFS_LPV, 32'h0, "lpv denied");
        chk("irq denied", irq, 1'b1);
        wr(`SFCD_OFS_IRQEN, 32'h0);
        chk("irq masked", irq, 1'b0);
        wr(`SFCD_OFS_IRQCLR, 32'h3f);
        rc(`SFCD_OFS_IRQST, 32'h0, "irq cleared");
        host_u.frame({`SFCD_OP_WREN}, rx);
        rc(`SFCD_OFS_STAT1, 32'h2, "wel set");
        host_u.frame({`SFCD_OP_WRLP, b1}, rx);
        rc(`SFCD_OFS_LPV, {24'h0, b1}, "lpv");
        rc(`SFCD_OFS_LPNV, 32'h0, "lpnv kept");
        rc(`SFCD_OFS_STAT1, 32'h0, "wel used");
        host_u.frame({`SFCD_OP_RDLP, 8'h00}, rx);
        chk("pattern read", rx, b1);
        host_u.frame({`SFCD_OP_WREN}, rx);
        host_u.frame({`SFCD_OP_PRLP, ~b1}, rx);
        rc(`SFCD_OFS_LPNV, {24'h0, ~b1}, "lpnv");
        for (int m = 0; m < 2; m++) begin
            b2 = 8'($urandom_range(0, 15));
            b1 = 8'($urandom);
            host_u.frame({`SFCD_OP_WREN}, rx);
            if (m == 0) host_u.frame({`SFCD_OP_WRREG, 8'h00, 8'h00, b2, b1}, rx);
            else host_u.frame({`SFCD_OP_WRREG, 8'h00, 8'h00, 8'h00, b2, b1}, rx);
            rc(8'h40 + {b2[3:0], 2'b00}, {24'h0, b1}, "any register");
            host_u.frame({`SFCD_OP_EN4}, rx);
            rc(`SFCD_OFS_CFG2, 32'h80, "wide mode");
        end
        host_u.frame({`SFCD_OP_EX4}, rx);
        rc(`SFCD_OFS_CFG2, 32'h0, "narrow mode");
        wr(`SFCD_OFS_IRQCLR, 32'h3f);
        for (int c = 0; c < 2; c++) begin
            wr(`SFCD_OFS_CTRL, c);
            wr(`SFCD_OFS_STAT1, 32'h60);
            host_u.frame({`SFCD_OP_CLRFAIL}, rx);
            rc(`SFCD_OFS_STAT1, c ? 32'h60 : 32'h0, "fail flags");
        end
        rc(`SFCD_OFS_IRQST, 32'h06, "clear and resume");
        q = {};
        repeat (5) q.push_back(8'($urandom));
        host_u.frame({`SFCD_OP_WREN}, rx);
        host_u.frame({`SFCD_OP_BOOT, q}, rx);
        rc(`SFCD_OFS_BOOT, boot_exp(q), "boot pattern");
        wr(`SFCD_OFS_ECC, 32'h18);
        wr(`SFCD_OFS_TRAP, 32'h5a);
        wr(`SFCD_OFS_ECNT, 32'h3);
        host_u.frame({`SFCD_OP_ECC_M, 8'h01, 8'h02, 8'h03, 8'h00}, rx);
        chk("ecc mode address", rx, 8'h18);
        host_u.frame({`SFCD_OP_ECC_4, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00}, rx);
        chk("ecc wide address", rx, 8'h18);
        host_u.frame({`SFCD_OP_CLEAR_ECC_STATE_CMD}, rx);
        for (int i = 0; i < 3; i++) rc(`SFCD_OFS_ECC + 8'(4 * i), 32'h0, "ecc state");
        q = {};
        repeat (8) q.push_back(8'($urandom));
        host_u.frame({`SFCD_OP_CHK, q}, rx);
        rc(`SFCD_OFS_RSTA, {q[0], q[1], q[2], q[3]}, "range start");
        rc(`SFCD_OFS_REND, {q[4], q[5], q[6], q[7]}, "range end");
        finish_test();
    end
endmodule
`default_nettype wire
